/* File: rtl/vtu_pkg.sv */
/*
  Shared constants and types of the vectored transfer unit: register map,
  control fields, transfer record layout and controller states.
  Assumes an APB master with 12-bit addresses and a 32-bit memory port.
*/
package vtu_pkg;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 4;
  localparam int EN_WORDS = 8;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_VBASE = 12'h004;
  localparam logic [11:0] OFS_STAT = 12'h008;
  localparam logic [11:0] OFS_EN = 12'h020;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_SHORT = 1;
  localparam int CTRL_BIGEND = 2;
  localparam int CTRL_MSTOP = 3;
  localparam logic [3:0] CTRL_RST = 4'h1;
  localparam logic [31:0] VBASE_RST = 32'h0000_0000;
  localparam logic [31:0] EN_RST = 32'h0000_0000;
  localparam int VBASE_LSB = 12;
  localparam int VBASE_CHK_LSB = 27;
  localparam int STAT_ACT = 15;
  localparam int MRA_MD = 6;
  localparam int MRA_SZ = 4;
  localparam int MRA_SM = 2;
  localparam int MRB_DTS = 4;
  localparam int MRB_DM = 2;
  localparam int REC_MRA_LSB = 24;
  localparam int REC_MRB_LSB = 16;
  localparam int CRA_LSB = 16;
  localparam int SADDR_W = 24;
  localparam logic [2:0] FULL_WORDS = 3'h4;
  localparam logic [2:0] SHORT_WORDS = 3'h3;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] AM_INC = 2'h2;
  localparam logic [1:0] AM_DEC = 2'h3;
  typedef enum logic [1:0] {
    MD_NORMAL = 2'h0,
    MD_REPEAT = 2'h1,
    MD_BLOCK = 2'h2
  } mode_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_VEC = 3'h1,
    ST_INFO = 3'h3,
    ST_XFER = 3'h2,
    ST_WBACK = 3'h6,
    ST_DONE = 3'h7
  } state_e;
endpackage

/* File: rtl/vectored_transfer_unit.sv */
/*
  Vectored transfer unit: interrupt-activated transfer engine with an APB
  register file, a memory master port and a small data FIFO.
  Assumes the interrupt controller holds a request until it is taken and
  the memory port answers every request with a one-cycle acknowledge.
*/
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/10ps

module vtu_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  logic push_w;
  logic pop_w;

  assign in_ready_o = cnt_ff != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_ff != '0;
  assign out_data_o = mem_ff[rp_ff];
  assign push_w = in_valid_i & in_ready_o;
  assign pop_w = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (ce_i && push_w) begin
      mem_ff[wp_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else if (ce_i) begin
      wp_ff <= push_w ? wp_ff + 1'b1 : wp_ff;
      rp_ff <= pop_w ? rp_ff + 1'b1 : rp_ff;
      cnt_ff <= cnt_ff + (AW+1)'(push_w) - (AW+1)'(pop_w);
    end
  end
endmodule // vtu_fifo

// Operation
// - Normal mode moves one unit per activation, up to 65,536 activations.
// - Repeat mode moves one unit per activation, repeat count 1 to 256.
// - Exhausted repeat area returns that side's address to its starting value.
// - Block mode moves a whole block of 1 to 256 units per activation.
// - Block mode counts 1 to 65,536 blocks, one block per activation.
// - Per-vector enable bit turns an interrupt into a transfer start.
// - Vector table base set in 4 KB steps within two legal ranges.
// - Table of 256 entries, each a 32-bit pointer to a record.
// - One record layout serves normal, repeat and block modes.
// - Record fields are placed according to the byte order setting.
// - Short-address format holds source and destination as 24-bit values.
// - Fetch four record longwords in full format, three in short.
// - Short addresses cover the low and the high 8 MB regions.
// - The unit is running after reset, no stop release needed.
// - One module-stop bit halts this unit and the general DMA peer.
// - Run bit gates operation; unit stays inactive while it is cleared.
module vectored_transfer_unit (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // APB slave
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Activation requests from the interrupt controller
  input wire logic irq_valid_i,
  input wire logic [7:0] irq_vector_i,
  output logic irq_ready_o,
  // Requests passed on to the processor
  output logic cpu_irq_valid_o,
  output logic [7:0] cpu_irq_vector_o,
  // Memory master
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [1:0] mem_size_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  // Shared module stop towards the general DMA peer
  output logic dma_peer_stop_o
);
  vtu_pkg::state_e st_ff;
  logic [3:0] ctrl_ff;
  logic [31:0] vbase_ff;
  logic [31:0] en_ff [vtu_pkg::EN_WORDS];
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic ready_ff;
  logic cpu_irq_ff;
  logic [7:0] cpu_vec_ff;
  logic mem_req_ff;
  logic mem_we_ff;
  logic [1:0] mem_size_ff;
  logic [31:0] mem_addr_ff;
  logic [31:0] mem_wdata_ff;
  logic peer_stop_ff;
  logic [7:0] vec_ff;
  logic [31:0] rec_addr_ff;
  logic [31:0] rec_ff [4];
  logic [2:0] idx_ff;
  logic fmt_short_ff;
  logic fmt_big_ff;
  logic [8:0] rd_left_ff;
  logic [8:0] wr_left_ff;
  logic end_ff;
  logic [7:0] mra_ff;
  logic [7:0] mrb_ff;
  logic [31:0] sar_ff;
  logic [31:0] dar_ff;
  logic [15:0] cra_ff;
  logic [15:0] crb_ff;

  function automatic logic [31:0] step_f(input logic [31:0] a, input logic [1:0] am,
                                         input logic [1:0] sz, input logic [8:0] n);
    logic [31:0] span;
    span = 32'(n) << sz;
    case (am)
      vtu_pkg::AM_INC: step_f = a + span;
      vtu_pkg::AM_DEC: step_f = a - span;
      default: step_f = a;
    endcase
  endfunction

  function automatic logic [31:0] sext_f(input logic [vtu_pkg::SADDR_W-1:0] a);
    sext_f = {{(32 - vtu_pkg::SADDR_W){a[vtu_pkg::SADDR_W-1]}}, a};
  endfunction

  // APB decode
  logic apb_acc_w;
  logic wr_w;
  logic en_rng_w;
  logic hit_w;
  logic vbase_ok_w;
  logic [31:0] stat_w;
  logic [31:0] rd_data_w;
  assign apb_acc_w = psel_i & penable_i & pready_ff;
  assign wr_w = apb_acc_w & pwrite_i;
  assign en_rng_w = paddr_i[11:5] == vtu_pkg::OFS_EN[11:5] && paddr_i[1:0] == 2'h0;
  assign hit_w = paddr_i == vtu_pkg::OFS_CTRL || paddr_i == vtu_pkg::OFS_VBASE ||
                 paddr_i == vtu_pkg::OFS_STAT || en_rng_w;
  assign vbase_ok_w = pwdata_i[31:vtu_pkg::VBASE_CHK_LSB] == '0 ||
                      pwdata_i[31:vtu_pkg::VBASE_CHK_LSB] == '1;
  assign stat_w = {16'h0, st_ff != vtu_pkg::ST_IDLE, 7'h0, vec_ff};
  assign rd_data_w = paddr_i == vtu_pkg::OFS_CTRL ? {28'h0, ctrl_ff} :
                     paddr_i == vtu_pkg::OFS_VBASE ? vbase_ff :
                     paddr_i == vtu_pkg::OFS_STAT ? stat_w :
                     en_rng_w ? en_ff[paddr_i[4:2]] : 32'h0;

  // One wait state keeps every APB output on a flop
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else if (ce_i) begin
      pready_ff <= psel_i & penable_i & ~pready_ff;
      pslverr_ff <= psel_i & penable_i & ~pready_ff & ~hit_w;
      prdata_ff <= (psel_i & penable_i & ~pready_ff) ? rd_data_w : 32'h0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_ff <= vtu_pkg::CTRL_RST;
      vbase_ff <= vtu_pkg::VBASE_RST;
      peer_stop_ff <= 1'b0;
    end else if (ce_i) begin
      peer_stop_ff <= ctrl_ff[vtu_pkg::CTRL_MSTOP];
      if (wr_w && paddr_i == vtu_pkg::OFS_CTRL) begin
        ctrl_ff <= pwdata_i[3:0];
      end
      // Out-of-range base writes are dropped so the table never lands in a hole
      if (wr_w && paddr_i == vtu_pkg::OFS_VBASE && vbase_ok_w) begin
        vbase_ff <= {pwdata_i[31:vtu_pkg::VBASE_LSB], 12'h0};
      end
    end
  end

  // Activation
  logic running_w;
  logic take_w;
  logic en_hit_w;
  logic go_w;
  logic clr_en_w;
  assign running_w = ctrl_ff[vtu_pkg::CTRL_RUN] & ~ctrl_ff[vtu_pkg::CTRL_MSTOP];
  assign take_w = irq_valid_i & ready_ff;
  assign en_hit_w = en_ff[irq_vector_i[7:5]][irq_vector_i[4:0]];
  assign go_w = take_w & en_hit_w & running_w;
  assign clr_en_w = st_ff == vtu_pkg::ST_DONE && end_ff;

  for (genvar gi = 0; gi < vtu_pkg::EN_WORDS; gi++) begin : g_en
    logic wsel_w;
    logic [31:0] clr_w;
    assign wsel_w = wr_w && paddr_i == vtu_pkg::OFS_EN + 12'(gi * 4);
    assign clr_w = (clr_en_w && vec_ff[7:5] == 3'(gi)) ? 32'h1 << vec_ff[4:0] : 32'h0;
    // The end-of-transfer clear wins over a software write in the same cycle
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        en_ff[gi] <= vtu_pkg::EN_RST;
      end else if (ce_i) begin
        en_ff[gi] <= (wsel_w ? pwdata_i : en_ff[gi]) & ~clr_w;
      end
    end
  end

  // Record decode, common to all modes
  logic [2:0] nw_w;
  logic idx_end_w;
  logic ack_w;
  logic ld_w;
  logic [31:0] rec_rd_w;
  logic [7:0] d_mra;
  logic [7:0] d_mrb;
  logic [31:0] d_sar;
  logic [31:0] d_dar;
  logic [31:0] d_cnt;
  logic [7:0] d_cral;
  logic [8:0] d_units;
  assign nw_w = fmt_short_ff ? vtu_pkg::SHORT_WORDS : vtu_pkg::FULL_WORDS;
  assign idx_end_w = idx_ff == nw_w;
  assign ack_w = mem_req_ff & mem_ack_i;
  assign ld_w = st_ff == vtu_pkg::ST_INFO && idx_end_w && !mem_req_ff;
  assign rec_rd_w = fmt_big_ff ? mem_rdata_i : {mem_rdata_i[15:0], mem_rdata_i[31:16]};
  assign d_mra = rec_ff[0][vtu_pkg::REC_MRA_LSB +: 8];
  assign d_mrb = fmt_short_ff ? rec_ff[1][vtu_pkg::REC_MRA_LSB +: 8] :
                 rec_ff[0][vtu_pkg::REC_MRB_LSB +: 8];
  assign d_sar = fmt_short_ff ? sext_f(rec_ff[0][vtu_pkg::SADDR_W-1:0]) : rec_ff[1];
  assign d_dar = fmt_short_ff ? sext_f(rec_ff[1][vtu_pkg::SADDR_W-1:0]) : rec_ff[2];
  assign d_cnt = fmt_short_ff ? rec_ff[2] : rec_ff[3];
  assign d_cral = d_cnt[vtu_pkg::CRA_LSB +: 8];
  assign d_units = d_mra[vtu_pkg::MRA_MD +: 2] == vtu_pkg::MD_BLOCK ?
                   {d_cral == 8'h0, d_cral} : 9'h1;

  // Working fields
  logic [1:0] md_w;
  logic [1:0] sz_w;
  logic [1:0] sm_w;
  logic [1:0] dm_w;
  logic dts_w;
  logic [7:0] crah_w;
  logic [7:0] cral_w;
  logic [8:0] rep_n_w;
  logic [31:0] wb_w;
  assign md_w = mra_ff[vtu_pkg::MRA_MD +: 2];
  assign sz_w = mra_ff[vtu_pkg::MRA_SZ +: 2];
  assign sm_w = mra_ff[vtu_pkg::MRA_SM +: 2];
  assign dm_w = mrb_ff[vtu_pkg::MRB_DM +: 2];
  assign dts_w = mrb_ff[vtu_pkg::MRB_DTS];
  assign crah_w = cra_ff[15:8];
  assign cral_w = cra_ff[7:0];
  assign rep_n_w = {crah_w == 8'h0, crah_w};
  assign wb_w = idx_ff == 3'h0 ? (fmt_short_ff ? {mra_ff, sar_ff[23:0]} : rec_ff[0]) :
                idx_ff == 3'h1 ? (fmt_short_ff ? {mrb_ff, dar_ff[23:0]} : sar_ff) :
                idx_ff == 3'h2 ? (fmt_short_ff ? {cra_ff, crb_ff} : dar_ff) :
                {cra_ff, crb_ff};

  // Data path through the FIFO
  logic f_in_ready_w;
  logic f_out_valid_w;
  logic [31:0] f_out_data_w;
  logic push_w;
  logic pop_w;
  logic do_wr_w;
  logic do_rd_w;
  logic xfer_done_w;
  assign push_w = ack_w && st_ff == vtu_pkg::ST_XFER && !mem_we_ff;
  assign pop_w = ack_w && st_ff == vtu_pkg::ST_XFER && mem_we_ff;
  // Drain when full or when all reads are out, so the FIFO really fills
  assign do_wr_w = st_ff == vtu_pkg::ST_XFER && !mem_req_ff && wr_left_ff != 9'h0 &&
                   f_out_valid_w && (!f_in_ready_w || rd_left_ff == 9'h0);
  assign do_rd_w = st_ff == vtu_pkg::ST_XFER && !mem_req_ff && !do_wr_w &&
                   rd_left_ff != 9'h0 && f_in_ready_w;
  assign xfer_done_w = st_ff == vtu_pkg::ST_XFER && rd_left_ff == 9'h0 &&
                       wr_left_ff == 9'h0 && !mem_req_ff;

  vtu_fifo #(
    .WIDTH(vtu_pkg::DATA_W),
    .DEPTH(vtu_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .in_valid_i(push_w),
    .in_ready_o(f_in_ready_w),
    .in_data_i(mem_rdata_i),
    .out_valid_o(f_out_valid_w),
    .out_ready_i(pop_w),
    .out_data_o(f_out_data_w)
  );

  // Memory request issue
  logic rec_iss_w;
  logic iss_w;
  logic iss_we_w;
  logic [1:0] iss_size_w;
  logic [31:0] iss_addr_w;
  logic [31:0] iss_data_w;
  assign rec_iss_w = (st_ff == vtu_pkg::ST_INFO || st_ff == vtu_pkg::ST_WBACK) &&
                     !mem_req_ff && !idx_end_w;
  assign iss_w = (st_ff == vtu_pkg::ST_IDLE && go_w) || rec_iss_w || do_rd_w || do_wr_w;
  assign iss_we_w = do_wr_w || st_ff == vtu_pkg::ST_WBACK;
  assign iss_size_w = (do_rd_w || do_wr_w) ? sz_w : vtu_pkg::SZ_LONG;
  assign iss_addr_w = st_ff == vtu_pkg::ST_IDLE ? vbase_ff + {22'h0, irq_vector_i, 2'h0} :
                      rec_iss_w ? rec_addr_ff + {27'h0, idx_ff, 2'h0} :
                      do_rd_w ? sar_ff : dar_ff;
  assign iss_data_w = do_wr_w ? f_out_data_w :
                      fmt_big_ff ? wb_w : {wb_w[15:0], wb_w[31:16]};

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_size_ff <= 2'h0;
      mem_addr_ff <= 32'h0;
      mem_wdata_ff <= 32'h0;
    end else if (ce_i) begin
      if (ack_w) begin
        mem_req_ff <= 1'b0;
      end else if (iss_w) begin
        mem_req_ff <= 1'b1;
        mem_we_ff <= iss_we_w;
        mem_size_ff <= iss_size_w;
        mem_addr_ff <= iss_addr_w;
        mem_wdata_ff <= iss_data_w;
      end
    end
  end

  // Sequencer
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= vtu_pkg::ST_IDLE;
      ready_ff <= 1'b1;
      cpu_irq_ff <= 1'b0;
      cpu_vec_ff <= 8'h0;
      vec_ff <= 8'h0;
      rec_addr_ff <= 32'h0;
      idx_ff <= 3'h0;
      fmt_short_ff <= 1'b0;
      fmt_big_ff <= 1'b0;
    end else if (ce_i) begin
      cpu_irq_ff <= 1'b0;
      case (st_ff)
        vtu_pkg::ST_IDLE: begin
          ready_ff <= !go_w;
          if (go_w) begin
            vec_ff <= irq_vector_i;
            fmt_short_ff <= ctrl_ff[vtu_pkg::CTRL_SHORT];
            fmt_big_ff <= ctrl_ff[vtu_pkg::CTRL_BIGEND];
            st_ff <= vtu_pkg::ST_VEC;
          end else if (take_w) begin
            cpu_irq_ff <= 1'b1;
            cpu_vec_ff <= irq_vector_i;
          end
        end
        vtu_pkg::ST_VEC: begin
          if (ack_w) begin
            rec_addr_ff <= mem_rdata_i;
            idx_ff <= 3'h0;
            st_ff <= vtu_pkg::ST_INFO;
          end
        end
        vtu_pkg::ST_INFO: begin
          if (ack_w) begin
            idx_ff <= idx_ff + 3'h1;
          end else if (ld_w) begin
            st_ff <= vtu_pkg::ST_XFER;
          end
        end
        vtu_pkg::ST_XFER: begin
          if (xfer_done_w) begin
            idx_ff <= 3'h0;
            st_ff <= vtu_pkg::ST_WBACK;
          end
        end
        vtu_pkg::ST_WBACK: begin
          if (ack_w) begin
            idx_ff <= idx_ff + 3'h1;
          end else if (idx_end_w && !mem_req_ff) begin
            st_ff <= vtu_pkg::ST_DONE;
          end
        end
        vtu_pkg::ST_DONE: begin
          cpu_irq_ff <= end_ff;
          cpu_vec_ff <= vec_ff;
          ready_ff <= 1'b1;
          st_ff <= vtu_pkg::ST_IDLE;
        end
        default: st_ff <= vtu_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_left_ff <= 9'h0;
      wr_left_ff <= 9'h0;
    end else if (ce_i) begin
      if (ld_w) begin
        rd_left_ff <= d_units;
        wr_left_ff <= d_units;
      end else begin
        rd_left_ff <= push_w ? rd_left_ff - 9'h1 : rd_left_ff;
        wr_left_ff <= pop_w ? wr_left_ff - 9'h1 : wr_left_ff;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < 4; i++) begin
        rec_ff[i] <= 32'h0;
      end
    end else if (ce_i && ack_w && st_ff == vtu_pkg::ST_INFO) begin
      rec_ff[idx_ff[1:0]] <= rec_rd_w;
    end
  end

  // Address and count update; the repeat side is rewound from its count
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mra_ff <= 8'h0;
      mrb_ff <= 8'h0;
      sar_ff <= 32'h0;
      dar_ff <= 32'h0;
      cra_ff <= 16'h0;
      crb_ff <= 16'h0;
      end_ff <= 1'b0;
    end else if (ce_i) begin
      if (ld_w) begin
        mra_ff <= d_mra;
        mrb_ff <= d_mrb;
        sar_ff <= d_sar;
        dar_ff <= d_dar;
        cra_ff <= d_cnt[31:16];
        crb_ff <= d_cnt[15:0];
      end
      if (push_w) begin
        sar_ff <= step_f(sar_ff, sm_w, sz_w, 9'h1);
      end
      if (pop_w) begin
        dar_ff <= step_f(dar_ff, dm_w, sz_w, 9'h1);
      end
      if (xfer_done_w) begin
        case (md_w)
          vtu_pkg::MD_REPEAT: begin
            end_ff <= 1'b0;
            cra_ff <= {crah_w, cral_w == 8'h1 ? crah_w : cral_w - 8'h1};
            if (cral_w == 8'h1 && dts_w) begin
              sar_ff <= step_f(sar_ff, sm_w ^ 2'h1, sz_w, rep_n_w);
            end else if (cral_w == 8'h1) begin
              dar_ff <= step_f(dar_ff, dm_w ^ 2'h1, sz_w, rep_n_w);
            end
          end
          vtu_pkg::MD_BLOCK: begin
            cra_ff <= {crah_w, crah_w};
            crb_ff <= crb_ff - 16'h1;
            end_ff <= crb_ff == 16'h1;
            if (dts_w) begin
              sar_ff <= step_f(sar_ff, sm_w ^ 2'h1, sz_w, rep_n_w);
            end else begin
              dar_ff <= step_f(dar_ff, dm_w ^ 2'h1, sz_w, rep_n_w);
            end
          end
          default: begin
            cra_ff <= cra_ff - 16'h1;
            end_ff <= cra_ff == 16'h1;
          end
        endcase
      end
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign irq_ready_o = ready_ff;
  assign cpu_irq_valid_o = cpu_irq_ff;
  assign cpu_irq_vector_o = cpu_vec_ff;
  assign mem_req_o = mem_req_ff;
  assign mem_we_o = mem_we_ff;
  assign mem_size_o = mem_size_ff;
  assign mem_addr_o = mem_addr_ff;
  assign mem_wdata_o = mem_wdata_ff;
  assign dma_peer_stop_o = peer_stop_ff;

  property p_fwd;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      ce_i && take_w && !en_hit_w |=> cpu_irq_ff && cpu_vec_ff == $past(irq_vector_i);
  endproperty
  a_fwd: assert property (p_fwd) else $error("plain request not passed on");
  property p_stop;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      ce_i && take_w && !running_w |=> st_ff == vtu_pkg::ST_IDLE && !mem_req_ff;
  endproperty
  a_stop: assert property (p_stop) else $error("stopped unit started");
  property p_peer;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      ce_i && ctrl_ff[vtu_pkg::CTRL_MSTOP] |=> peer_stop_ff;
  endproperty
  a_peer: assert property (p_peer) else $error("peer stop missing");
  property p_vbase;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      vbase_ff[11:0] == 12'h0 && (vbase_ff[31:27] == 5'h0 || vbase_ff[31:27] == 5'h1f);
  endproperty
  a_vbase: assert property (p_vbase) else $error("illegal table base");
  property p_vec;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      ce_i && go_w |=> mem_req_ff && mem_addr_ff == vbase_ff + {22'h0, vec_ff, 2'h0};
  endproperty
  a_vec: assert property (p_vec) else $error("wrong vector entry");
  property p_info;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      st_ff == vtu_pkg::ST_INFO && mem_req_ff |->
        mem_addr_ff - rec_addr_ff < (fmt_short_ff ? 32'hc : 32'h10) && !mem_we_ff;
  endproperty
  a_info: assert property (p_info) else $error("record fetch out of bounds");
  property p_short;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      ce_i && ld_w && fmt_short_ff |=> sar_ff[31:23] == 9'h0 || sar_ff[31:23] == 9'h1ff;
  endproperty
  a_short: assert property (p_short) else $error("short address out of space");
  property p_units;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      ce_i && ld_w |=> rd_left_ff == (md_w == vtu_pkg::MD_BLOCK ?
                                      {cral_w == 8'h0, cral_w} : 9'h1);
  endproperty
  a_units: assert property (p_units) else $error("wrong unit count");
  property p_end;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      ce_i && clr_en_w |=> cpu_irq_ff && !en_ff[vec_ff[7:5]][vec_ff[4:0]];
  endproperty
  a_end: assert property (p_end) else $error("transfer end not reported");
  property p_wback;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      st_ff == vtu_pkg::ST_WBACK && mem_req_ff |-> mem_we_ff && mem_addr_ff - rec_addr_ff < 32'h10;
  endproperty
  a_wback: assert property (p_wback) else $error("write-back off record");
endmodule // vectored_transfer_unit

/* File: dv/vtu_mem_model.sv */
/* Memory model on the unit's master port.
   Assumes one request at a time, held until acknowledged. */
`timescale 1ns/10ps
module vtu_mem_model (
  // Clock
  input wire logic clk_i,
  // Request
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  // Answer
  output logic ack_o,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [logic [31:0]];
  int wait_n = 1;
  initial begin
    ack_o = 1'b0;
    rdata_o = 32'h0;
  end
  // Read data scrambled outside the ack cycle so stale values never pass
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (req_i && !ack_o) begin
      if (wait_n == 0) begin
        ack_o <= 1'b1;
        wait_n = $urandom_range(2);
        if (we_i) mem[addr_i] = wdata_i;
        else rdata_o <= mem.exists(addr_i) ? mem[addr_i] : 32'h0;
      end else wait_n--;
    end
  end
endmodule // vtu_mem_model

/* File: dv/vectored_transfer_unit_tb_top.sv */
/* Bench of the vectored transfer unit: APB set-up and activations.
   Assumes the memory model answers every request. */
`timescale 1ns/10ps
module vectored_transfer_unit_tb_top;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [11:0] paddr_i = 12'h0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd, dat;
  logic pready_o, pslverr_o, err, irq_ready_o, cpu_irq_valid_o, dma_peer_stop_o;
  logic irq_valid_i = 1'b0;
  logic [7:0] irq_vector_i = 8'h0, cpu_irq_vector_o, last_vec, v;
  logic mem_req_o, mem_we_o, mem_ack_i;
  logic [1:0] mem_size_o;
  logic [31:0] mem_addr_o, mem_wdata_o, mem_rdata_i;
  int n_fail = 0, comparisons = 0, cycles = 0, n_cpu = 0;
  initial forever #2.5 core_clk_i = ~core_clk_i;
  vectored_transfer_unit dut (.core_clk_i, .rst_b_i, .ce_i(1'b1), .paddr_i, .psel_i,
    .penable_i, .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .irq_valid_i,
    .irq_vector_i, .irq_ready_o, .cpu_irq_valid_o, .cpu_irq_vector_o, .mem_req_o,
    .mem_we_o, .mem_size_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i,
    .dma_peer_stop_o);
  vtu_mem_model u_mem (.clk_i(core_clk_i), .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
  always @(posedge core_clk_i) begin
    cycles++;
    if (mem_req_o === 1'b1 && mem_ack_i === 1'b1) chk({30'h0, mem_size_o}, 32'h2);
    if (cpu_irq_valid_o === 1'b1) begin
      n_cpu++;
      last_vec = cpu_irq_vector_o;
    end
    if (cycles == 20000) begin
      n_fail++;
      final_report();
    end
  end
  function automatic logic [31:0] cnt_word(input int n);
    return {n[15:0], 16'h0};
  endfunction
  function automatic logic [31:0] swap_h(input logic [31:0] w);
    return {w[15:0], w[31:16]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Releases the bus and idles one cycle so back-to-back calls never collide
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic act(input logic [7:0] vec);
    irq_valid_i <= 1'b1;
    irq_vector_i <= vec;
    do @(posedge core_clk_i); while (irq_ready_o !== 1'b1);
    irq_valid_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    while (irq_ready_o !== 1'b1) @(posedge core_clk_i);
    @(posedge core_clk_i);
  endtask
  task automatic final_report();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(60));
    dat = $urandom;
    v = 8'($urandom_range(200, 10));
    u_mem.mem[32'h1014] = 32'h200;
    u_mem.mem[32'h200] = 32'h2808_0000;
    u_mem.mem[32'h204] = 32'h300;
    u_mem.mem[32'h208] = 32'h400;
    u_mem.mem[32'h20c] = cnt_word(2);
    u_mem.mem[32'h300] = dat;
    u_mem.mem[32'h304] = ~dat;
    u_mem.mem[32'h1018] = 32'h500;
    u_mem.mem[32'h500] = 32'h8000_68ff;
    u_mem.mem[32'h504] = 32'h0600_1000;
    u_mem.mem[32'h508] = 32'h0000_0202;
    u_mem.mem[32'hffff_8000] = dat;
    u_mem.mem[32'hffff_8004] = ~dat;
    u_mem.mem[32'h101c] = 32'h700;
    u_mem.mem[32'h700] = 32'ha808_0000;
    u_mem.mem[32'h704] = 32'h800;
    u_mem.mem[32'h708] = 32'h900;
    u_mem.mem[32'h70c] = 32'h0202_0001;
    u_mem.mem[32'h800] = ~dat;
    u_mem.mem[32'h804] = dat;
    repeat (20) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    apb(1'b0, vtu_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("reset and map test done");
    apb(1'b1, vtu_pkg::OFS_VBASE, 32'h0800_0000);
    apb(1'b0, vtu_pkg::OFS_VBASE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, vtu_pkg::OFS_VBASE, 32'hf800_0123);
    apb(1'b0, vtu_pkg::OFS_VBASE, 32'h0);
    chk(rd, 32'hf800_0000);
    apb(1'b1, vtu_pkg::OFS_VBASE, 32'h0000_1000);
    $display("table base test done");
    act(v);
    chk({24'h0, last_vec}, {24'h0, v});
    apb(1'b1, vtu_pkg::OFS_EN, 32'h20);
    apb(1'b1, vtu_pkg::OFS_CTRL, 32'h4);
    act(8'h5);
    chk(n_cpu, 2);
    apb(1'b1, vtu_pkg::OFS_CTRL, 32'hd);
    @(posedge core_clk_i);
    chk({31'h0, dma_peer_stop_o}, 32'h1);
    act(8'h5);
    chk(n_cpu, 3);
    $display("pass-on and stop test done");
    apb(1'b1, vtu_pkg::OFS_CTRL, 32'h5);
    act(8'h5);
    chk(u_mem.mem[32'h400], dat);
    chk(u_mem.mem[32'h204], 32'h304);
    chk(u_mem.mem[32'h208], 32'h404);
    chk(u_mem.mem[32'h20c], cnt_word(1));
    chk(n_cpu, 3);
    act(8'h5);
    chk(u_mem.mem[32'h404], ~dat);
    chk(u_mem.mem[32'h20c], cnt_word(0));
    chk({24'h0, last_vec}, 32'h5);
    apb(1'b0, vtu_pkg::OFS_EN, 32'h0);
    chk(rd, 32'h0);
    $display("normal transfer test done");
    apb(1'b1, vtu_pkg::OFS_EN, 32'hc0);
    apb(1'b1, vtu_pkg::OFS_CTRL, 32'h3);
    act(8'h6);
    chk(u_mem.mem[32'h600], dat);
    chk(u_mem.mem[32'h500], swap_h(32'h68ff_8004));
    act(8'h6);
    chk(u_mem.mem[32'h600], ~dat);
    chk(u_mem.mem[32'h500], swap_h(32'h68ff_8000));
    chk(u_mem.mem[32'h508], swap_h(32'h0202_0000));
    $display("repeat test done");
    apb(1'b1, vtu_pkg::OFS_CTRL, 32'h5);
    act(8'h7);
    chk(u_mem.mem[32'h900], ~dat);
    chk(u_mem.mem[32'h904], dat);
    chk(u_mem.mem[32'h704], 32'h808);
    chk(u_mem.mem[32'h708], 32'h900);
    chk(u_mem.mem[32'h70c], 32'h0202_0000);
    chk({24'h0, last_vec}, 32'h7);
    apb(1'b0, vtu_pkg::OFS_EN, 32'h0);
    chk(rd, 32'h40);
    $display("block test done");
    final_report();
  end
endmodule // vectored_transfer_unit_tb_top
